/* File: core/decode_pkg.sv */
/*
 * Constants, encodings and carrier types for the instruction decoder.
 * Assumes one 100 MHz system clock and a synchronous active-high reset.
 */
package decode_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    // instruction cycle phases
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [1:0] PH_WRITE = 2'h3;
    // field positions
    localparam int FAM_HI = 13;
    localparam int FAM_LO = 12;
    localparam int D_BIT = 7;
    localparam int F_HI = 6;
    localparam int F_LO = 0;
    localparam int B_HI = 9;
    localparam int B_LO = 7;
    localparam int BOP_HI = 11;
    localparam int BOP_LO = 10;
    localparam int IM_DIR = 3;
    localparam int IM_N = 2;
    localparam int IM_MM_HI = 1;
    localparam int IM_MM_LO = 0;
    localparam int IO_N = 6;
    // bit-family operations
    localparam logic [1:0] BOP_CLR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_SKC = 2'h2;
    localparam logic [1:0] BOP_SKS = 2'h3;
    // value / mask pairs; masked-out bits are don't-care
    localparam logic [13:0] NOP_WORD = 14'h0000;
    localparam logic [13:0] CTL_VAL = 14'h0000;
    localparam logic [13:0] CTL_MSK = 14'h3f80;
    localparam logic [13:0] RET_VAL = 14'h0008;
    localparam logic [13:0] IEX_VAL = 14'h0009;
    localparam logic [13:0] CLA_VAL = 14'h000a;
    localparam logic [13:0] JAO_VAL = 14'h000b;
    localparam logic [13:0] FULL_MSK = 14'h3fff;
    localparam logic [13:0] IMV_VAL = 14'h0010;
    localparam logic [13:0] IMV_MSK = 14'h3ff0;
    localparam logic [13:0] DSZ_VAL = 14'h0b00;
    localparam logic [13:0] ISZ_VAL = 14'h0f00;
    localparam logic [13:0] OP_MSK = 14'h3f00;
    localparam logic [13:0] CALL_VAL = 14'h2000;
    localparam logic [13:0] AJMP_VAL = 14'h2800;
    localparam logic [13:0] CJ_MSK = 14'h3800;
    localparam logic [13:0] XLIT_VAL = 14'h3400;
    localparam logic [13:0] XLIT_MSK = 14'h3c00;
    localparam logic [13:0] RJMP_VAL = 14'h3200;
    localparam logic [13:0] RJMP_MSK = 14'h3e00;
    localparam logic [13:0] IOFS_VAL = 14'h3f00;
    localparam logic [6:0] IND0_ADDR = 7'h00;
    localparam logic [6:0] IND1_ADDR = 7'h01;
    localparam logic [7:0] ZERO_AFTER_DEC = 8'h01;
    localparam logic [7:0] ZERO_AFTER_INC = 8'hff;

    typedef enum logic [1:0] {fam_byte, fam_bit, fam_lit} fam_type;
    typedef enum logic [2:0] {
        flow_seq, flow_call, flow_ret, flow_jump, flow_skip
    } flow_type;
    typedef enum logic [2:0] {
        sk_none, sk_bclr, sk_bset, sk_dec, sk_inc
    } skip_type;
    typedef enum logic [1:0] {exec_st, ind_st, flush_st} st_type;

    typedef struct packed {
        fam_type fam;
        flow_type flow;
        skip_type skip;
        logic file_ref;
        logic dsel;
        logic wr_file;
        logic wr_acc;
        logic ind_ref;
        logic ind_move;
        logic ptr_sel;
        logic [1:0] ptr_mode;
        logic [6:0] addr;
        logic [2:0] bitp;
    } dec_type;

    typedef struct packed {
        logic cyc_start;
        logic fetch_req;
        logic rd_en;
        logic wr_file;
        logic wr_acc;
        logic flush;
        logic stall;
        logic skip_taken;
        fam_type fam;
        flow_type flow;
        logic [6:0] file_addr;
        logic [2:0] bit_pos;
        logic ind_move;
        logic ptr_sel;
        logic [1:0] ptr_mode;
    } dec_out_type;
endpackage

/* File: core/instr_decode_timing.sv */
/*
 * Instruction decoder and instruction-cycle sequencer.
 * Assumes program memory presents a word while fetch_req is high and the
 * file register space returns read data in the cycle rd_en is high, both
 * on sys_clk.
 */
`timescale 1ns/1ps
module instr_decode_timing (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [13:0] instr_word,
    input wire logic instr_valid,
    input wire logic [7:0] file_rdata,
    input wire logic [1:0] ptr_in_prog,
    output decode_pkg::dec_out_type dec_out
);
    typedef struct packed {
        decode_pkg::st_type st;
        logic [1:0] q;
        logic [13:0] instr;
        logic [7:0] rdata;
        logic two_pend;
        decode_pkg::dec_out_type o;
    } state_type;

    state_type s_r;
    state_type s_nxt;
    decode_pkg::dec_type cur_d;
    decode_pkg::dec_type nxt_d;
    logic taken;
    logic ind_hit;
    logic end_cyc;

    // masked compare: bits outside the mask never affect decoding
    function automatic logic match(input logic [13:0] w,
                                   input logic [13:0] val,
                                   input logic [13:0] msk);
        match = ((w & msk) == (val & msk));
    endfunction

    // classify one word into family, flow class and operand fields
    function automatic decode_pkg::dec_type decode_word(
        input logic [13:0] w);
        decode_pkg::dec_type r;
        r = '0;
        r.flow = decode_pkg::flow_seq;
        r.skip = decode_pkg::sk_none;
        r.addr = w[decode_pkg::F_HI:decode_pkg::F_LO];
        r.bitp = w[decode_pkg::B_HI:decode_pkg::B_LO];
        // family from the top two bits
        if (w[decode_pkg::FAM_HI]) begin
            r.fam = decode_pkg::fam_lit;
        end else if (w[decode_pkg::FAM_LO]) begin
            r.fam = decode_pkg::fam_bit;
        end else begin
            r.fam = decode_pkg::fam_byte;
        end
        case (r.fam)
            decode_pkg::fam_bit: begin
                r.file_ref = 1'b1;
                case (w[decode_pkg::BOP_HI:decode_pkg::BOP_LO])
                    decode_pkg::BOP_CLR, decode_pkg::BOP_SET: begin
                        r.wr_file = 1'b1;
                    end
                    decode_pkg::BOP_SKC: begin
                        r.skip = decode_pkg::sk_bclr;
                        r.flow = decode_pkg::flow_skip;
                    end
                    default: begin
                        r.skip = decode_pkg::sk_bset;
                        r.flow = decode_pkg::flow_skip;
                    end
                endcase
            end
            decode_pkg::fam_byte: begin
                if (match(w, decode_pkg::CTL_VAL, decode_pkg::CTL_MSK)) begin
                    // control words; only the indirect move has a file operand
                    if (match(w, decode_pkg::RET_VAL, decode_pkg::FULL_MSK)
                        || match(w, decode_pkg::IEX_VAL,
                                 decode_pkg::FULL_MSK)) begin
                        r.flow = decode_pkg::flow_ret;
                    end else if (match(w, decode_pkg::CLA_VAL,
                                       decode_pkg::FULL_MSK)) begin
                        r.flow = decode_pkg::flow_call;
                    end else if (match(w, decode_pkg::JAO_VAL,
                                       decode_pkg::FULL_MSK)) begin
                        r.flow = decode_pkg::flow_jump;
                    end else if (match(w, decode_pkg::IMV_VAL,
                                       decode_pkg::IMV_MSK)) begin
                        r.file_ref = 1'b1;
                        r.ind_move = 1'b1;
                        r.ptr_sel = w[decode_pkg::IM_N];
                        r.ptr_mode =
                            w[decode_pkg::IM_MM_HI:decode_pkg::IM_MM_LO];
                        r.wr_file = w[decode_pkg::IM_DIR];
                        r.wr_acc = ~w[decode_pkg::IM_DIR];
                    end
                end else begin
                    // read-modify-write on f, result routed by d
                    r.file_ref = 1'b1;
                    r.dsel = 1'b1;
                    r.wr_file = w[decode_pkg::D_BIT];
                    r.wr_acc = ~w[decode_pkg::D_BIT];
                    if (match(w, decode_pkg::DSZ_VAL,
                              decode_pkg::OP_MSK)) begin
                        r.skip = decode_pkg::sk_dec;
                        r.flow = decode_pkg::flow_skip;
                    end else if (match(w, decode_pkg::ISZ_VAL,
                                       decode_pkg::OP_MSK)) begin
                        r.skip = decode_pkg::sk_inc;
                        r.flow = decode_pkg::flow_skip;
                    end
                end
            end
            default: begin
                if (match(w, decode_pkg::CALL_VAL, decode_pkg::CJ_MSK)) begin
                    r.flow = decode_pkg::flow_call;
                end else if (match(w, decode_pkg::AJMP_VAL,
                                   decode_pkg::CJ_MSK)
                             || match(w, decode_pkg::RJMP_VAL,
                                      decode_pkg::RJMP_MSK)) begin
                    r.flow = decode_pkg::flow_jump;
                end else if (match(w, decode_pkg::XLIT_VAL,
                                   decode_pkg::XLIT_MSK)) begin
                    r.flow = decode_pkg::flow_ret;
                    r.wr_acc = 1'b1;
                end else if (match(w, decode_pkg::IOFS_VAL,
                                   decode_pkg::OP_MSK)) begin
                    r.file_ref = 1'b1;
                    r.ind_ref = 1'b1;
                    r.ptr_sel = w[decode_pkg::IO_N];
                    r.wr_acc = 1'b1;
                end
            end
        endcase
        // file operand 0 or 1 goes through an indirect data port
        if (r.ind_move) begin
            r.ind_ref = 1'b1;
        end else if (r.file_ref && !r.ind_ref
                     && r.fam != decode_pkg::fam_lit) begin
            r.ind_ref = (r.addr == decode_pkg::IND0_ADDR)
                        || (r.addr == decode_pkg::IND1_ADDR);
            r.ptr_sel = r.addr[0];
        end
        decode_word = r;
    endfunction

    // skip condition from the value read in the read phase
    function automatic logic skip_eval(input decode_pkg::skip_type k,
                                       input logic [7:0] v,
                                       input logic [2:0] b);
        case (k)
            decode_pkg::sk_bclr: skip_eval = ~v[b];
            decode_pkg::sk_bset: skip_eval = v[b];
            decode_pkg::sk_dec: skip_eval = (v == decode_pkg::ZERO_AFTER_DEC);
            decode_pkg::sk_inc: skip_eval = (v == decode_pkg::ZERO_AFTER_INC);
            default: skip_eval = 1'b0;
        endcase
    endfunction

    // next-state: phase counter, cycle sequencing, output strobes
    always_comb begin
        s_nxt = s_r;
        cur_d = decode_word(s_r.instr);
        taken = skip_eval(cur_d.skip, s_r.rdata, cur_d.bitp);
        ind_hit = cur_d.ind_ref && ptr_in_prog[cur_d.ptr_sel];
        end_cyc = (s_r.q == decode_pkg::PH_LAST);
        s_nxt.q = s_r.q + 2'h1; // four phases per cycle
        if (s_r.st == decode_pkg::exec_st && s_r.o.rd_en) begin
            s_nxt.rdata = file_rdata;
        end
        if (end_cyc) begin
            s_nxt.o.skip_taken = 1'b0;
            case (s_r.st)
                decode_pkg::exec_st: begin
                    s_nxt.o.skip_taken = taken;
                    s_nxt.two_pend = (cur_d.flow != decode_pkg::flow_seq)
                                     && (cur_d.flow != decode_pkg::flow_skip
                                         || taken);
                    if (ind_hit) begin
                        s_nxt.st = decode_pkg::ind_st;
                    end else if (s_nxt.two_pend) begin
                        s_nxt.st = decode_pkg::flush_st;
                    end else begin
                        s_nxt.st = decode_pkg::exec_st;
                    end
                end
                decode_pkg::ind_st: begin
                    s_nxt.st = s_r.two_pend ? decode_pkg::flush_st
                                            : decode_pkg::exec_st;
                end
                default: begin
                    s_nxt.st = decode_pkg::exec_st;
                end
            endcase
            s_nxt.two_pend = (s_nxt.st == decode_pkg::ind_st)
                             && s_nxt.two_pend;
            if (s_nxt.st == decode_pkg::exec_st) begin
                // whole 14-bit word taken at once
                s_nxt.instr = instr_valid ? instr_word : decode_pkg::NOP_WORD;
            end
        end
        nxt_d = decode_word(s_nxt.instr);
        s_nxt.o.cyc_start = (s_nxt.q == decode_pkg::PH_FIRST);
        s_nxt.o.fetch_req = (s_nxt.q == decode_pkg::PH_LAST);
        // read always precedes any write of the file
        s_nxt.o.rd_en = (s_nxt.st == decode_pkg::exec_st) && nxt_d.file_ref
                        && (s_nxt.q == decode_pkg::PH_READ);
        s_nxt.o.wr_file = (s_nxt.st == decode_pkg::exec_st) && nxt_d.wr_file
                          && (s_nxt.q == decode_pkg::PH_WRITE);
        s_nxt.o.wr_acc = (s_nxt.st == decode_pkg::exec_st) && nxt_d.wr_acc
                         && (s_nxt.q == decode_pkg::PH_WRITE);
        s_nxt.o.flush = (s_nxt.st == decode_pkg::flush_st);
        s_nxt.o.stall = (s_nxt.st == decode_pkg::ind_st);
        s_nxt.o.fam = nxt_d.fam;
        s_nxt.o.flow = nxt_d.flow;
        s_nxt.o.file_addr = nxt_d.addr;
        s_nxt.o.bit_pos = nxt_d.bitp;
        s_nxt.o.ind_move = nxt_d.ind_move;
        s_nxt.o.ptr_sel = nxt_d.ptr_sel;
        s_nxt.o.ptr_mode = nxt_d.ptr_mode;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.st <= decode_pkg::exec_st;
            s_r.o.cyc_start <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dec_out = s_r.o;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_exec_end;
        s_r.st == decode_pkg::exec_st && end_cyc;
    endsequence
    sequence s_flush_cycle;
        (s_r.st == decode_pkg::flush_st)[*4] ##1
            (s_r.st == decode_pkg::exec_st);
    endsequence

    a_cycle_period: assert property (
        s_r.o.cyc_start |=> !s_r.o.cyc_start[*3] ##1 s_r.o.cyc_start)
        else $error("instruction cycle is not four clocks");
    a_single_cycle: assert property (
        s_exec_end and (cur_d.flow == decode_pkg::flow_seq && !ind_hit)
        |=> (s_r.st == decode_pkg::exec_st)[*4])
        else $error("plain instruction took extra cycle");
    a_call_two: assert property (
        s_exec_end and (cur_d.flow == decode_pkg::flow_call && !ind_hit)
        |=> s_flush_cycle)
        else $error("call not two cycles");
    a_return_two: assert property (
        s_exec_end and (cur_d.flow == decode_pkg::flow_ret && !ind_hit)
        |=> s_flush_cycle)
        else $error("return not two cycles");
    a_branch_two: assert property (
        s_exec_end and (!ind_hit && (cur_d.flow == decode_pkg::flow_jump
            || (cur_d.flow == decode_pkg::flow_skip && taken)))
        |=> s_flush_cycle)
        else $error("branch or taken skip not two cycles");
    a_indirect_extra: assert property (
        s_exec_end and ind_hit
        |=> (s_r.st == decode_pkg::ind_st)[*4] ##1
            (s_r.st != decode_pkg::ind_st))
        else $error("indirect program access lacks one extra cycle");
    a_read_before_write: assert property (
        s_r.o.wr_file |-> $past(s_r.o.rd_en, 2))
        else $error("file written without prior read");
    a_dest_route: assert property (
        s_r.o.rd_en && cur_d.dsel |-> ##2
        (s_r.o.wr_file == s_r.instr[decode_pkg::D_BIT]
         && s_r.o.wr_acc == !s_r.instr[decode_pkg::D_BIT]))
        else $error("destination select misrouted");
    a_bit_position: assert property (
        s_r.o.rd_en && s_r.o.fam == decode_pkg::fam_bit
        |-> s_r.o.bit_pos == s_r.instr[decode_pkg::B_HI:decode_pkg::B_LO])
        else $error("bit position field wrong");

    // strobe placement and quiet discarded cycles
    a_write_phase: assert property (
        s_r.o.wr_file || s_r.o.wr_acc
        |-> s_r.q == decode_pkg::PH_WRITE
            && !(s_r.o.wr_file && s_r.o.wr_acc))
        else $error("result strobe out of phase or doubled");
    a_discard_quiet: assert property (
        s_r.o.flush || s_r.o.stall
        |-> !(s_r.o.rd_en || s_r.o.wr_file || s_r.o.wr_acc))
        else $error("file or accumulator touched in a discarded cycle");
    a_skip_marks: assert property (
        s_r.o.skip_taken |-> s_r.o.flush || s_r.o.stall)
        else $error("taken skip without a discarded cycle");
    a_fetch_start: assert property (
        s_r.o.fetch_req |=> s_r.o.cyc_start)
        else $error("fetch not followed by a cycle start");
    a_word_load: assert property (
        !$stable(s_r.instr) |-> s_r.o.cyc_start)
        else $error("instruction word changed inside a cycle");
endmodule // instr_decode_timing

/* File: dv/prog_file_model.sv */
/*
 * Program memory stream and file register space facing the decoder.
 * Assumes dec_out is registered on sys_clk and the bench queues words.
 */
`timescale 1ns/1ps
module prog_file_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire decode_pkg::dec_out_type dec_out,
    output logic [13:0] instr_word,
    output logic instr_valid,
    output logic [7:0] file_rdata
);
    logic [14:0] prog_q[$];
    logic [7:0] regs [0:127];
    logic [7:0] junk_r;

    // one queued word per fetch slot; a valid NOP during reset; otherwise outside the slot the bus is scrambled
    initial begin
        instr_word = 14'h0000;
        instr_valid = 1'b0;
        junk_r = 8'h5a;
        for (int i = 0; i < 128; i++) begin
            regs[i] = 8'h00;
        end
        forever begin
            @(posedge sys_clk);
            #1;
            junk_r = junk_r + 8'h3b;
            if (dec_out.fetch_req && prog_q.size() > 0) begin
                {instr_valid, instr_word} = prog_q.pop_front();
            end else if (dec_out.fetch_req || sys_rst) begin
                {instr_valid, instr_word} = {1'b1, 14'h0000};
            end else begin
                {instr_valid, instr_word} = {1'b0, ~instr_word};
            end
        end
    end

    // read data answers at once; a changing pattern while not read
    assign file_rdata = dec_out.rd_en ? regs[dec_out.file_addr] : junk_r;
endmodule // prog_file_model

/* File: dv/mcu_instruction_decode_timing_test.sv */
/*
 * Self-checking bench for the instruction decoder and cycle sequencer.
 * Assumes the decoder and its package are compiled first.
 */
`timescale 1ns/1ps
module mcu_instruction_decode_timing_test;
    logic sys_clk;
    logic sys_rst;
    logic [13:0] instr_word;
    logic instr_valid;
    logic [7:0] file_rdata;
    logic [1:0] ptr_in_prog;
    decode_pkg::dec_out_type dec_out;
    decode_pkg::dec_out_type obs [0:7];
    int mismatches;
    int compares;
    int cycles;

    instr_decode_timing dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .instr_valid(instr_valid), .file_rdata(file_rdata),
        .ptr_in_prog(ptr_in_prog), .dec_out(dec_out)
    );
    prog_file_model partner_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .dec_out(dec_out),
        .instr_word(instr_word), .instr_valid(instr_valid),
        .file_rdata(file_rdata)
    );

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            $display("ERROR %0t: run timed out", $time);
            end_sim;
        end
    end

    task end_sim;
        $display("counts: mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: flag got %b exp %b", $time, got, exp);
        end
    endtask

    task chk_field(input logic [13:0] got, input logic [13:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: field got %h exp %h", $time, got, exp);
        end
    endtask

    task tick;
        @(posedge sys_clk);
        #1;
    endtask

    // reset for two edges, then first fetch on the third clock after release
    task do_reset;
        sys_rst = 1'b1;
        tick;
        chk_flag(dec_out.cyc_start, 1'b1);
        chk_flag(dec_out.fetch_req, 1'b0);
        tick;
        sys_rst = 1'b0;
        for (int i = 1; i <= 3; i++) begin
            tick;
            chk_flag(dec_out.fetch_req, i == 3);
        end
    endtask

    // issue one word, observe its execute cycle and the cycle after it
    task run(input logic [14:0] w, input logic [1:0] pip,
             input logic rd, wf, wa, fl, st, sk);
        int n;
        n = 0;
        while (!(dec_out.cyc_start === 1'b1 && dec_out.flush === 1'b0 &&
                 dec_out.stall === 1'b0) && n < 40) begin
            tick;
            n++;
        end
        chk_flag(n < 40, 1'b1);
        partner_u.prog_q.push_back(w);
        ptr_in_prog = pip;
        repeat (3) tick;
        for (int i = 0; i < 8; i++) begin
            tick;
            obs[i] = dec_out;
        end
        chk_flag(obs[0].cyc_start, 1'b1);
        chk_flag(obs[3].fetch_req, 1'b1);
        chk_flag(obs[1].rd_en, rd);
        chk_flag(obs[2].rd_en, 1'b0);
        chk_flag(obs[3].wr_file, wf);
        chk_flag(obs[3].wr_acc, wa);
        for (int i = 4; i < 8; i++) begin
            chk_flag(obs[i].flush, fl);
            chk_flag(obs[i].stall, st);
            chk_flag(obs[i].skip_taken, sk);
        end
    endtask

    // byte ops at the address boundary, both destinations, invalid word
    task t_byte;
        run({1'b1, 14'h07ff}, 2'h0, 1, 1, 0, 0, 0, 0);
        chk_field(14'(obs[0].fam), 14'(decode_pkg::fam_byte));
        chk_field(14'(obs[0].file_addr), 14'h007f);
        run({1'b1, 14'h0755}, 2'h0, 1, 0, 1, 0, 0, 0);
        chk_field(14'(obs[0].file_addr), 14'h0055);
        run({1'b0, 14'h07ff}, 2'h0, 0, 0, 0, 0, 0, 0);
    endtask

    // bit set on every bit position, plus one bit clear
    task t_bits;
        for (int b = 0; b < 8; b++) begin
            run({1'b1, 14'h1422 | 14'(b << 7)}, 2'h0,
                1, 1, 0, 0, 0, 0);
            chk_field(14'(obs[0].bit_pos), 14'(b));
            chk_field(14'(obs[0].fam), 14'(decode_pkg::fam_bit));
        end
        run({1'b1, 14'h11a2}, 2'h0, 1, 1, 0, 0, 0, 0);
    endtask

    // skips taken and not taken for every skip kind
    task t_skip;
        logic [13:0] w [0:7] = '{14'h19b0, 14'h19b0, 14'h1db0, 14'h1db0,
                                 14'h0bb0, 14'h0bb0, 14'h0fb0, 14'h0fb0};
        logic [7:0] v [0:7] = '{8'h08, 8'hf7, 8'h08, 8'hf7,
                                8'h01, 8'h02, 8'hff, 8'h00};
        logic [7:0] sk = 8'b01010110;
        logic [7:0] wf = 8'b11110000;
        for (int i = 0; i < 8; i++) begin
            partner_u.regs[7'h30] = v[i];
            run({1'b1, w[i]}, 2'h0, 1, wf[i], 0, sk[i], 0, sk[i]);
            chk_field(14'(obs[0].file_addr), 14'h0030);
        end
    endtask

    // calls, returns and jumps take a second, discarded cycle
    task t_flow;
        logic [13:0] w [0:9] = '{14'h2123, 14'h000a, 14'h0008, 14'h0009,
                                 14'h3455, 14'h3755, 14'h2812, 14'h3205,
                                 14'h000b, 14'h0000};
        logic [2:0] f [0:9] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2,
                                3'h3, 3'h3, 3'h3, 3'h0};
        logic [9:0] wa = 10'b0000110000;
        for (int i = 0; i < 10; i++) begin
            run({1'b1, w[i]}, 2'h0, 0, 0, wa[i], i < 9, 0, 0);
            chk_field(14'(obs[0].flow), 14'(f[i]));
            chk_flag(obs[0].fam == decode_pkg::fam_lit, w[i][13]);
        end
    endtask

    // indirect ports, pointer selection and move modes
    task t_ind;
        run({1'b1, 14'h0781}, 2'h2, 1, 1, 0, 0, 1, 0);
        run({1'b1, 14'h0781}, 2'h1, 1, 1, 0, 0, 0, 0);
        run({1'b1, 14'h0780}, 2'h1, 1, 1, 0, 0, 1, 0);
        for (int m = 0; m < 4; m++) begin
            run({1'b1, 14'h0014 | 14'(m)}, 2'h0,
                1, 0, 1, 0, 0, 0);
            chk_flag(obs[0].ind_move, 1'b1);
            chk_flag(obs[0].ptr_sel, 1'b1);
            chk_field(14'(obs[0].ptr_mode), 14'(m));
        end
        run({1'b1, 14'h0010}, 2'h1, 1, 0, 1, 0, 1, 0);
        chk_flag(obs[0].ptr_sel, 1'b0);
        run({1'b1, 14'h3f40}, 2'h2, 1, 0, 1, 0, 1, 0);
        chk_flag(obs[0].ptr_sel, 1'b1);
    endtask

    // main sequence, with a second reset in mid-run
    initial begin
        mismatches = 0;
        compares = 0;
        cycles = 0;
        sys_rst = 1'b1;
        ptr_in_prog = 2'h0;
        do_reset;
        t_byte;
        t_bits;
        t_skip;
        t_flow;
        t_ind;
        do_reset;
        t_byte;
        end_sim;
    end
endmodule // mcu_instruction_decode_timing_test
